// file: rtl/ssitpg_pkg.sv
package ssitpg_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_RX_FIXED = 8'h04;
  localparam logic [7:0] ADDR_TX_EXP   = 8'h08;
  localparam logic [7:0] ADDR_DELAY    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_ERRCNT   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  // Control field positions
  localparam int CTRL_RXMODE_LSB = 0;
  localparam int CTRL_TXMODE_LSB = 4;
  localparam int CTRL_LVDS_BIT   = 8;
  localparam int CTRL_ENH_BIT    = 9;
  localparam int CTRL_LOOP_BIT   = 10;
  // Delay field positions, each DLY_W bits wide
  localparam int DLY_W       = 4;
  localparam int DLY_CLK_LSB = 0;
  localparam int DLY_STB_LSB = 4;
  localparam int DLY_DAT_LSB = 8;
  // Status and interrupt bit positions
  localparam int ST_CHECKED_BIT = 0;
  localparam int ST_PASS_BIT    = 1;
  localparam int IRQ_ERR_BIT    = 0;
  localparam int IRQ_MATCH_BIT  = 1;
  // Reset values
  localparam logic [31:0] RX_FIXED_RST = 32'h0000_0000;
  localparam logic [31:0] TX_EXP_RST   = 32'h0000_0000;
  localparam logic [11:0] DELAY_RST    = 12'h000;
  localparam logic [15:0] PRBS_SEED    = 16'hFFFF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_FIXED  = 3'h1,
    MODE_NIBBLE = 3'h2,
    MODE_RAMP16 = 3'h3,
    MODE_PRBS15 = 3'h4,
    MODE_PRBS7  = 3'h5
  } ssitpg_mode_e;

  // Transmit lanes arriving from the baseband
  typedef struct packed {
    logic        strobe;
    logic [15:0] i;
    logic [15:0] q;
  } ssitpg_lane_s;

  // Receive interface driven toward the baseband
  typedef struct packed {
    logic        clk;
    logic        strobe;
    logic [31:0] i;
    logic [31:0] q;
  } ssitpg_rxout_s;
endpackage

// file: rtl/ssitpg_top.sv
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
// Overview of operation
// - Test mode replaces receive samples with pattern
// - CMOS fixed: low nibble on each of the low four nibbles
// - LVDS fixed: low sixteen bits per lane
// - Six modes: normal, fixed, nibble, ramp, PRBS
// - Nibble ramp: low four nibbles equal sample count
// - 16-bit ramp: I equals Q, counts up
// - Enhanced CMOS fixed: two 16-bit copies
// - Enhanced LVDS: two copies, fixed or ramp
// - No PRBS in enhanced 32-bit mode
// - Transmit checker: ramp, PRBS or fixed
// - Checker result readable by software
// - Loopback sends transmit data to receive
// - Separate step delays: clock, strobe, data
module ssitpg_top #(
  parameter int DLY_DEPTH = 16
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  output logic [1:0]                    s_axi_bresp,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  input  wire logic [7:0]               s_axi_araddr,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  input  wire logic                     link_clk,
  input  wire ssitpg_pkg::ssitpg_lane_s tx_lane,
  input  wire logic [31:0]              rx_samp_i,
  input  wire logic [31:0]              rx_samp_q,
  input  wire logic                     rx_samp_strobe,
  output ssitpg_pkg::ssitpg_rxout_s     rx_out,
  output logic                          irq
);

  typedef struct packed {
    logic                                    aw_have;
    logic [7:0]                              aw_addr;
    logic                                    w_have;
    logic [31:0]                             w_data;
    logic [3:0]                              w_strb;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic                                    rvalid;
    logic [1:0]                              rresp;
    logic [31:0]                             rdata;
    ssitpg_pkg::ssitpg_mode_e                rx_pattern_select;
    ssitpg_pkg::ssitpg_mode_e                tx_pattern_select;
    logic                                    lvds_sample_interface;
    logic                                    enh32;
    logic                                    loopback;
    logic [31:0]                             rx_fixed_value;
    logic [31:0]                             tx_expected_value;
    logic [11:0]                             dly;
    logic                                    checked;
    logic                                    pass;
    logic [15:0]                             err_cnt;
    logic [1:0]                              irq_stat;
    logic [1:0]                              irq_mask;
    logic                                    sclk1;
    logic                                    sclk2;
    logic                                    sclk3;
    ssitpg_pkg::ssitpg_lane_s                lane1;
    ssitpg_pkg::ssitpg_lane_s                lane2;
    logic [15:0]                             gen_prbs;
    logic [15:0]                             ramp_value;
    logic [15:0]                             chk_prev;
    logic                                    chk_first;
    ssitpg_pkg::ssitpg_rxout_s               cur;
    ssitpg_pkg::ssitpg_rxout_s [DLY_DEPTH-1:0] dl;
    ssitpg_pkg::ssitpg_rxout_s               out;
  } ssitpg_state_s;

  ssitpg_state_s s_r;
  ssitpg_state_s s_nxt;

  // Advance a 16-bit lane word by sixteen serial PRBS steps
  function automatic logic [15:0] prbs16(input logic [15:0] w, input logic sel7);
    logic [15:0] v;
    logic        nb;
    v  = w;
    nb = 1'b0;
    for (int k = 0; k < 16; k++) begin
      nb = sel7 ? (v[6] ^ v[5]) : (v[14] ^ v[13]);
      v  = {v[14:0], nb};
    end
    return v;
  endfunction

  // Apply AXI byte strobes to a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  logic                      rise, wr_go, rd_go, chk_ok, chk_act;
  logic [1:0]                ev, w1c;
  logic [31:0]               wv;
  logic [15:0]               f16, ti;
  ssitpg_pkg::ssitpg_mode_e  rxm, newtx;
  // Handshake outputs and registered data outputs
  assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_have && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign rx_out        = s_r.out;
  assign irq           = |(s_r.irq_stat & s_r.irq_mask);

  // Next-state logic for the whole block
  always_comb begin
    s_nxt   = s_r;
    ev      = 2'h0;
    w1c     = 2'h0;
    wv      = 32'h0;
    newtx   = s_r.tx_pattern_select;
    chk_ok  = 1'b1;
    chk_act = 1'b0;
    f16     = s_r.rx_fixed_value[15:0];
    ti      = s_r.lane2.i;
    // Link clock and lanes pass two flops before use
    s_nxt.sclk1 = link_clk;
    s_nxt.sclk2 = s_r.sclk1;
    s_nxt.sclk3 = s_r.sclk2;
    s_nxt.lane1 = tx_lane;
    s_nxt.lane2 = s_r.lane1;
    rise        = s_r.sclk2 && !s_r.sclk3;

    // AXI write address and data, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
    wr_go = s_r.aw_have && s_r.w_have;
    if (wr_go) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = ssitpg_pkg::RESP_OKAY;
      unique case (s_r.aw_addr)
        ssitpg_pkg::ADDR_CTRL: begin
          wv = merge({21'h0, s_r.loopback, s_r.enh32, s_r.lvds_sample_interface, 1'b0,
                      s_r.tx_pattern_select, 1'b0, s_r.rx_pattern_select}, s_r.w_data, s_r.w_strb);
          s_nxt.rx_pattern_select     = ssitpg_pkg::ssitpg_mode_e'(wv[ssitpg_pkg::CTRL_RXMODE_LSB +: 3]);
          newtx                       = ssitpg_pkg::ssitpg_mode_e'(wv[ssitpg_pkg::CTRL_TXMODE_LSB +: 3]);
          s_nxt.tx_pattern_select     = newtx;
          s_nxt.lvds_sample_interface = wv[ssitpg_pkg::CTRL_LVDS_BIT];
          s_nxt.enh32                 = wv[ssitpg_pkg::CTRL_ENH_BIT];
          s_nxt.loopback              = wv[ssitpg_pkg::CTRL_LOOP_BIT];
          s_nxt.ramp_value            = 16'h0000; // A new setting restarts the ramps; a ramp step in the same cycle wins
          // Arming a check clears the result; selecting normal keeps it
          if (newtx != ssitpg_pkg::MODE_NORMAL) begin
            s_nxt.checked   = 1'b0;
            s_nxt.pass      = 1'b1;
            s_nxt.err_cnt   = 16'h0000;
            s_nxt.chk_first = 1'b1;
          end
        end
        ssitpg_pkg::ADDR_RX_FIXED: s_nxt.rx_fixed_value = merge(s_r.rx_fixed_value, s_r.w_data, s_r.w_strb);
        ssitpg_pkg::ADDR_TX_EXP: s_nxt.tx_expected_value = merge(s_r.tx_expected_value, s_r.w_data, s_r.w_strb);
        ssitpg_pkg::ADDR_DELAY: begin
          wv        = merge({20'h0, s_r.dly}, s_r.w_data, s_r.w_strb);
          s_nxt.dly = wv[11:0];
        end
        ssitpg_pkg::ADDR_IRQ_STAT: w1c = s_r.w_data[1:0] & {2{s_r.w_strb[0]}};
        ssitpg_pkg::ADDR_IRQ_MASK: if (s_r.w_strb[0]) s_nxt.irq_mask = s_r.w_data[1:0];
        ssitpg_pkg::ADDR_STATUS, ssitpg_pkg::ADDR_ERRCNT: ;
        default: s_nxt.bresp = ssitpg_pkg::RESP_SLVERR;
      endcase
    end

    // AXI read, answered with registered data
    rd_go = s_axi_arvalid && s_axi_arready;
    if (s_axi_rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = ssitpg_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        ssitpg_pkg::ADDR_CTRL: s_nxt.rdata = {21'h0, s_r.loopback, s_r.enh32, s_r.lvds_sample_interface,
                                              1'b0, s_r.tx_pattern_select, 1'b0, s_r.rx_pattern_select};
        ssitpg_pkg::ADDR_RX_FIXED: s_nxt.rdata = s_r.rx_fixed_value;
        ssitpg_pkg::ADDR_TX_EXP:   s_nxt.rdata = s_r.tx_expected_value;
        ssitpg_pkg::ADDR_DELAY:    s_nxt.rdata = {20'h0, s_r.dly};
        ssitpg_pkg::ADDR_STATUS:   s_nxt.rdata = {30'h0, s_r.pass, s_r.checked};
        ssitpg_pkg::ADDR_ERRCNT:   s_nxt.rdata = {16'h0, s_r.err_cnt};
        ssitpg_pkg::ADDR_IRQ_STAT: s_nxt.rdata = {30'h0, s_r.irq_stat};
        ssitpg_pkg::ADDR_IRQ_MASK: s_nxt.rdata = {30'h0, s_r.irq_mask};
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = ssitpg_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Effective receive mode: PRBS needs LVDS, not enhanced; nibble needs CMOS
    rxm = s_r.rx_pattern_select;
    if ((rxm == ssitpg_pkg::MODE_PRBS15 || rxm == ssitpg_pkg::MODE_PRBS7) &&
        (!s_r.lvds_sample_interface || s_r.enh32)) rxm = ssitpg_pkg::MODE_NORMAL;
    if (rxm == ssitpg_pkg::MODE_NIBBLE && s_r.lvds_sample_interface) rxm = ssitpg_pkg::MODE_NORMAL;
    if (rxm > ssitpg_pkg::MODE_PRBS7) rxm = ssitpg_pkg::MODE_NORMAL;

    // Receive generator, one sample per link clock rising edge
    s_nxt.cur.clk = s_r.sclk2;
    if (rise) begin
      s_nxt.cur.strobe = 1'b1;
      if (rxm != ssitpg_pkg::MODE_NIBBLE && rxm != ssitpg_pkg::MODE_RAMP16) s_nxt.ramp_value = 16'h0000;
      if (s_r.loopback) begin
        s_nxt.cur.i      = {16'h0000, s_r.lane2.i};
        s_nxt.cur.q      = {16'h0000, s_r.lane2.q};
        s_nxt.cur.strobe = s_r.lane2.strobe;
      end else begin
        unique case (rxm)
          ssitpg_pkg::MODE_FIXED: begin
            if (s_r.enh32) begin
              s_nxt.cur.i = {2{f16}};
              s_nxt.cur.q = {2{f16}};
            end else if (s_r.lvds_sample_interface) begin
              s_nxt.cur.i = {16'h0000, f16};
              s_nxt.cur.q = {16'h0000, f16};
            end else begin
              s_nxt.cur.i = {16'h0000, {4{f16[3:0]}}};
              s_nxt.cur.q = {16'h0000, {4{f16[3:0]}}};
            end
          end
          ssitpg_pkg::MODE_NIBBLE: begin
            s_nxt.cur.i      = {16'h0000, {4{s_r.ramp_value[3:0]}}};
            s_nxt.cur.q      = {16'h0000, {4{s_r.ramp_value[3:0]}}};
            s_nxt.ramp_value = s_r.ramp_value + 16'h0001;
          end
          ssitpg_pkg::MODE_RAMP16: begin
            s_nxt.cur.i      = s_r.enh32 ? {2{s_r.ramp_value}} : {16'h0000, s_r.ramp_value};
            s_nxt.cur.q      = s_r.enh32 ? {2{s_r.ramp_value}} : {16'h0000, s_r.ramp_value};
            s_nxt.ramp_value = s_r.ramp_value + 16'h0001;
          end
          ssitpg_pkg::MODE_PRBS15, ssitpg_pkg::MODE_PRBS7: begin
            s_nxt.cur.i    = {16'h0000, s_r.gen_prbs};
            s_nxt.cur.q    = {16'h0000, s_r.gen_prbs};
            s_nxt.gen_prbs = prbs16(s_r.gen_prbs, rxm == ssitpg_pkg::MODE_PRBS7);
          end
          default: begin
            s_nxt.cur.i      = rx_samp_i;
            s_nxt.cur.q      = rx_samp_q;
            s_nxt.cur.strobe = rx_samp_strobe;
          end
        endcase
      end
    end

    // Transmit checker, self-aligning on ramp and PRBS
    unique case (s_r.tx_pattern_select)
      ssitpg_pkg::MODE_FIXED: begin
        chk_act = 1'b1;
        chk_ok  = ({s_r.lane2.i, s_r.lane2.q} == s_r.tx_expected_value);
      end
      ssitpg_pkg::MODE_NIBBLE: begin
        chk_act = !s_r.lvds_sample_interface;
        chk_ok  = (ti == s_r.lane2.q) && (ti == {4{ti[3:0]}}) &&
                  (s_r.chk_first || ti[3:0] == s_r.chk_prev[3:0] + 4'h1);
      end
      ssitpg_pkg::MODE_RAMP16: begin
        chk_act = 1'b1;
        chk_ok  = (ti == s_r.lane2.q) && (s_r.chk_first || ti == s_r.chk_prev + 16'h0001);
      end
      ssitpg_pkg::MODE_PRBS15, ssitpg_pkg::MODE_PRBS7: begin
        chk_act = s_r.lvds_sample_interface && !s_r.enh32;
        chk_ok  = (ti == s_r.lane2.q) && (s_r.chk_first ||
                  ti == prbs16(s_r.chk_prev, s_r.tx_pattern_select == ssitpg_pkg::MODE_PRBS7));
      end
      default: chk_act = 1'b0;
    endcase
    if (rise && chk_act && s_r.lane2.strobe) begin
      s_nxt.chk_prev  = ti;
      s_nxt.chk_first = 1'b0;
      s_nxt.checked   = 1'b1;
      if (chk_ok) begin
        ev[ssitpg_pkg::IRQ_MATCH_BIT] = 1'b1;
      end else begin
        ev[ssitpg_pkg::IRQ_ERR_BIT] = 1'b1;
        s_nxt.pass                  = 1'b0;
        if (s_nxt.err_cnt != 16'hFFFF) s_nxt.err_cnt = s_nxt.err_cnt + 16'h0001; // Counts from a fresh arm too
      end
    end

    // Sticky events, set wins over a write-one clear
    s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;
    // Output delay line, separate taps for clock, strobe and data
    s_nxt.dl         = {s_r.dl[DLY_DEPTH-2:0], s_r.cur};
    s_nxt.out.clk    = s_r.dl[s_r.dly[ssitpg_pkg::DLY_CLK_LSB +: ssitpg_pkg::DLY_W]].clk;
    s_nxt.out.strobe = s_r.dl[s_r.dly[ssitpg_pkg::DLY_STB_LSB +: ssitpg_pkg::DLY_W]].strobe;
    s_nxt.out.i      = s_r.dl[s_r.dly[ssitpg_pkg::DLY_DAT_LSB +: ssitpg_pkg::DLY_W]].i;
    s_nxt.out.q      = s_r.dl[s_r.dly[ssitpg_pkg::DLY_DAT_LSB +: ssitpg_pkg::DLY_W]].q;
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r                   <= '0;
      s_r.rx_pattern_select <= ssitpg_pkg::MODE_NORMAL;
      s_r.tx_pattern_select <= ssitpg_pkg::MODE_NORMAL;
      s_r.rx_fixed_value    <= ssitpg_pkg::RX_FIXED_RST;
      s_r.tx_expected_value <= ssitpg_pkg::TX_EXP_RST;
      s_r.dly               <= ssitpg_pkg::DELAY_RST;
      s_r.gen_prbs          <= ssitpg_pkg::PRBS_SEED;
      s_r.pass              <= 1'b1;
      s_r.chk_first         <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // ssitpg_top

// file: sim/ssitpg_monitor.sv
`timescale 1ns/100ps
module ssitpg_monitor (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic [7:0]                s_axi_awaddr,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic [31:0]               s_axi_wdata,
  input wire logic [3:0]                s_axi_wstrb,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [7:0]                s_axi_araddr,
  input wire logic                      s_axi_rvalid,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic [1:0]                s_axi_rresp,
  input wire logic                      link_clk,
  input wire ssitpg_pkg::ssitpg_rxout_s rx_out,
  input wire logic                      irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Register bus answers
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("Read answer late");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("Write answer late");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("Write answer dropped");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("Write taken during answer");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > ssitpg_pkg::ADDR_IRQ_MASK
      |=> s_axi_rresp == ssitpg_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read accepted");
  property p_mask_clear;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == ssitpg_pkg::ADDR_IRQ_MASK && s_axi_wvalid
      && s_axi_wready && s_axi_wstrb[0] && s_axi_wdata[1:0] == 2'h0 |-> ##[1:3] !irq;
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("Interrupt stays with mask clear");
  // Receive interface timing
  property p_rx_clk;
    $rose(link_clk) |-> ##[3:20] $rose(rx_out.clk);
  endproperty
  a_rx_clk: assert property (p_rx_clk) else $error("Receive clock not following link");
  property p_rx_hold;
    !$stable(rx_out.i) |=> $stable(rx_out.i) [*4];
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("Receive sample not held");
endmodule // ssitpg_monitor

// file: sim/ssitpg_bb_model.sv
`timescale 1ns/100ps
module ssitpg_bb_model (
  input  wire logic                run,
  input  wire logic [2:0]          kind,
  input  wire logic [31:0]         pat,
  output logic                     link_clk,
  output ssitpg_pkg::ssitpg_lane_s tx_lane
);
  logic [15:0] cnt;
  logic [15:0] pr;
  // Link clock runs only in frames; lanes change on its falling edge
  initial begin
    link_clk = 1'b0;
    tx_lane = '0;
    cnt = 16'h0000;
    pr = 16'hACE1; // Any non-zero start; the checker aligns itself
    #130;
    forever begin
      if (run) begin
        #400 link_clk = 1'b1;
        #400 link_clk = 1'b0;
        case (kind)
          3'h1: tx_lane = {1'b1, pat};
          3'h3: tx_lane = {1'b1, cnt, cnt};
          3'h2: tx_lane = {1'b1, {4{cnt[3:0]}}, {4{cnt[3:0]}}};
          3'h4, 3'h5: begin
            for (int j = 0; j < 16; j++) pr = {pr[14:0], kind[0] ? pr[6] ^ pr[5] : pr[14] ^ pr[13]};
            tx_lane = {1'b1, pr, pr};
          end
          3'h6: tx_lane = {1'b1, cnt, ~cnt};
          default: tx_lane = {1'b0, ~tx_lane.i, ~tx_lane.q};
        endcase
        cnt = cnt + 16'h0001;
      end else begin
        #100;
      end
    end
  end
endmodule // ssitpg_bb_model

// file: sim/tb_top.sv
`timescale 1ns/100ps
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (act), (exp)); end end
module tb_top;
  logic                      aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic                      s_axi_rready, rx_samp_strobe, run, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                      s_axi_arready, s_axi_rvalid, irq, link_clk;
  logic [1:0]                s_axi_bresp, s_axi_rresp, resp;
  logic [2:0]                kind;
  logic [3:0]                s_axi_wstrb;
  logic [7:0]                s_axi_awaddr, s_axi_araddr;
  logic [31:0]               s_axi_wdata, s_axi_rdata, rx_samp_i, rx_samp_q, pat, a, b, qv, d;
  ssitpg_pkg::ssitpg_lane_s  tx_lane;
  ssitpg_pkg::ssitpg_rxout_s rx_out;
  int                        fails, n_tests;

  ssitpg_top #(.DLY_DEPTH(16)) ssitpg_top_i (.*);
  ssitpg_bb_model ssitpg_bb_model_i (.*);

  // System clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic give_up();
    `CHK(1'b0, 1'b1)
    finish_test();
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (!s_axi_bvalid && k < 60);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 60) give_up();
  endtask

  // Bus read and compare
  task automatic chk_rd(input logic [7:0] ad, input logic [31:0] ex);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (!s_axi_rvalid && k < 60);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 60) give_up();
    `CHK(d, ex)
  endtask

  // Receive sample capture on the falling output clock
  task automatic wait_lvl(input logic v);
    int k;
    for (k = 0; k < 40 && rx_out.clk !== v; k++) @(posedge aclk);
    if (k >= 40) give_up();
  endtask

  task automatic samp();
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    a = b;
    b = rx_out.i;
    qv = rx_out.q;
  endtask

  // Control write; f is loopback, enhanced, lvds
  task automatic ctrl(input logic [2:0] rm, input logic [2:0] tm, input logic [2:0] f);
    wr(ssitpg_pkg::ADDR_CTRL, {21'h0, f, 1'b0, tm, 1'b0, rm});
    repeat (3) samp();
  endtask

  task automatic t_regs();
    chk_rd(ssitpg_pkg::ADDR_CTRL, 32'h0000_0000);
    chk_rd(ssitpg_pkg::ADDR_DELAY, 32'h0000_0000);
    chk_rd(ssitpg_pkg::ADDR_STATUS, 32'h0000_0002);
    chk_rd(8'h40, 32'h0000_0000);
    `CHK(resp, ssitpg_pkg::RESP_SLVERR)
    wr(8'h44, 32'hFFFF_FFFF);
    `CHK(resp, ssitpg_pkg::RESP_SLVERR)
    repeat (2) samp();
    `CHK({b, qv}, {rx_samp_i, rx_samp_q})
    `CHK(rx_out.strobe, rx_samp_strobe)
    $display("Registers and normal path done");
  endtask

  task automatic t_rx_pat();
    logic [31:0] ex [4];
    logic [31:0] cat;
    logic [7:0]  bad;
    int          len;
    ex = '{32'h0000_4444, 32'h0000_1234, 32'h1234_1234, 32'h1234_1234};
    wr(ssitpg_pkg::ADDR_RX_FIXED, 32'hA5C3_1234);
    for (int m = 0; m < 4; m++) begin
      ctrl(3'h1, 3'h0, {1'b0, m[1:0]});
      `CHK({b, qv}, {ex[m], ex[m]})
    end
    ctrl(3'h3, 3'h0, 3'b001);
    `CHK({b, qv}, {a + 32'h1, a + 32'h1})
    ctrl(3'h2, 3'h0, 3'b000);
    `CHK(b, {16'h0, {4{a[3:0] + 4'h1}}})
    ctrl(3'h3, 3'h0, 3'b011);
    `CHK(b, {2{a[15:0] + 16'h1}})
    ctrl(3'h4, 3'h0, 3'b011);
    `CHK(b, rx_samp_i)
    ctrl(3'h5, 3'h0, 3'b000);
    `CHK(b, rx_samp_i)
    for (int m = 0; m < 2; m++) begin
      len = m ? 7 : 15;
      ctrl(m ? 3'h5 : 3'h4, 3'h0, 3'b001);
      cat = {a[15:0], b[15:0]};
      bad = 8'h00;
      for (int n = 16; n < 32; n++) bad += 8'(cat[31 - n] ^ cat[31 - n + len] ^ cat[30 - n + len]);
      `CHK({b[31:16], bad}, 24'h0)
    end
    $display("Receive pattern test done");
  endtask

  task automatic t_tx_chk();
    wr(ssitpg_pkg::ADDR_TX_EXP, 32'hBEEF_1234);
    wr(ssitpg_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    pat <= 32'hBEEF_1234;
    kind <= 3'h1;
    ctrl(3'h0, 3'h1, 3'b001);
    chk_rd(ssitpg_pkg::ADDR_STATUS, 32'h0000_0003);
    chk_rd(ssitpg_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    `CHK(irq, 1'b0)
    pat <= 32'hBEEF_0000;
    repeat (2) samp();
    chk_rd(ssitpg_pkg::ADDR_STATUS, 32'h0000_0001);
    `CHK({irq, |d}, 2'b11)
    kind <= 3'h0;
    repeat (2) samp();
    wr(ssitpg_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    chk_rd(ssitpg_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(ssitpg_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    ctrl(3'h0, 3'h0, 3'b001);
    chk_rd(ssitpg_pkg::ADDR_STATUS, 32'h0000_0001);
    kind <= 3'h3;
    ctrl(3'h0, 3'h3, 3'b001);
    chk_rd(ssitpg_pkg::ADDR_STATUS, 32'h0000_0003);
    kind <= 3'h6;
    repeat (2) samp();
    chk_rd(ssitpg_pkg::ADDR_STATUS, 32'h0000_0001);
    kind <= 3'h0;
    repeat (2) samp();
    kind <= 3'h2;
    ctrl(3'h0, 3'h2, 3'b000);
    chk_rd(ssitpg_pkg::ADDR_STATUS, 32'h0000_0003);
    kind <= 3'h0;
    repeat (2) samp();
    kind <= 3'h4;
    ctrl(3'h0, 3'h4, 3'b001);
    chk_rd(ssitpg_pkg::ADDR_STATUS, 32'h0000_0003);
    kind <= 3'h0;
    repeat (2) samp();
    ctrl(3'h0, 3'h5, 3'b011);
    chk_rd(ssitpg_pkg::ADDR_STATUS, 32'h0000_0002);
    $display("Transmit checker test done");
  endtask

  task automatic t_loop_dly();
    int k;
    pat <= 32'h1111_2222;
    kind <= 3'h1; // link already active on both sides
    ctrl(3'h1, 3'h0, 3'b101);
    `CHK({b[15:0], qv[15:0]}, 32'h1111_2222)
    kind <= 3'h0;
    ctrl(3'h3, 3'h0, 3'b001);
    run <= 1'b0;
    repeat (30) @(posedge aclk);
    wr(ssitpg_pkg::ADDR_DELAY, 32'h0000_0500);
    chk_rd(ssitpg_pkg::ADDR_DELAY, 32'h0000_0500);
    run <= 1'b1;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    d = rx_out.i;
    for (k = 0; k < 20 && rx_out.i === d; k++) @(posedge aclk);
    `CHK(k[7:0], 8'h05)
    $display("Loopback and delay test done");
  endtask

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, kind, pat, b} = '0;
    s_axi_wstrb = 4'hF;
    rx_samp_i = 32'h1357_9BDF;
    rx_samp_q = 32'h2468_ACE0;
    rx_samp_strobe = 1'b1;
    run = 1'b1;
    fails = 0;
    n_tests = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rx_pat();
    t_tx_chk();
    t_loop_dly();
    finish_test();
  end
endmodule // tb_top

bind ssitpg_top ssitpg_monitor ssitpg_monitor_i (.*);
